// ===== agt_params.svh
`ifndef AGT_PARAMS_SVH
`define AGT_PARAMS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define AGT_CLK_NS 10
`define AGT_PROFILE_NS 400000
`define AGT_CORR_NS 100000
`define AGT_PROFILE_CYC (`AGT_PROFILE_NS / `AGT_CLK_NS)
`define AGT_CORR_CYC (`AGT_CORR_NS / `AGT_CLK_NS)
`define AGT_INTERP_SHIFT 2
`define AGT_INTERP_LAST 3'h3

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AGT_OFF_CMD 8'h00
`define AGT_OFF_STAT 8'h04
`define AGT_OFF_RATIO 8'h08
`define AGT_OFF_SLAVE_CFG 8'h0c
`define AGT_OFF_OFFSET 8'h10
`define AGT_OFF_SCALE 8'h14
`define AGT_OFF_NULL 8'h18
`define AGT_OFF_ORDER 8'h1c
`define AGT_OFF_FULL_SCALE 8'h20
`define AGT_OFF_MAX_VEL 8'h24
`define AGT_OFF_MAX_ACC 8'h28
`define AGT_OFF_CORNER 8'h2c
`define AGT_OFF_SETPOINT 8'h30

// ----------------------------------------
// Field positions
// ----------------------------------------
`define AGT_CMD_GEAR_ON 0
`define AGT_CMD_GEAR_OFF 1
`define AGT_CMD_TRACK_ON 2
`define AGT_CMD_TRACK_OFF 3
`define AGT_CMD_TRACK_VEL 4
`define AGT_ST_GEAR 0
`define AGT_ST_TRACK 1
`define AGT_ST_VEL 2
`define AGT_ST_ERR 3
`define AGT_ST_CFG 4
`define AGT_CFG_SIZE_LO 8
`define AGT_ONE_POSITIONER 4'h1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define AGT_RST_RATIO 32'h0001_0000
`define AGT_RST_SCALE 32'h0001_0000
`define AGT_RST_ORDER 4'h1
`define AGT_RST_FS_SHIFT 5'h0f
`define AGT_RST_CORNER 32'h0000_1000
`define AGT_RST_MAX_VEL 32'h0000_1000
`define AGT_RST_MAX_ACC 32'h0000_0100

`endif

// ===== agt_pkg.sv
package agt_pkg;

  typedef enum logic [2:0] {
    grp_not_referenced,
    grp_homing,
    grp_ready,
    grp_moving,
    grp_busy
  } agt_group_type;

  typedef struct packed {
    logic signed [31:0] pos;
    logic signed [31:0] comp;
  } agt_axis_type;

  typedef enum logic [1:0] {
    calc_idle,
    calc_power,
    calc_apply
  } agt_calc_type;

endpackage

// ===== agt_core.sv
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "agt_params.svh"

module agt_core #(
  parameter int unsigned PROFILE_CYC = `AGT_PROFILE_CYC,
  parameter int unsigned CORR_CYC = `AGT_CORR_CYC
) (
  input wire logic clk, // 100 MHz clock
  input wire logic nrst, // Synchronous reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic [15:0] adc_sample, // Analog input word from pins
  input wire agt_pkg::agt_axis_type master_fb, // Selected master position
  input wire agt_pkg::agt_axis_type slave_fb, // Controlled axis position
  input wire agt_pkg::agt_group_type slave_state, // Controlled group state
  input wire agt_pkg::agt_group_type master_state, // Master group state
  input wire logic slave_move_req, // Independent move for the slave
  output logic slave_move_refuse, // Move refused
  output logic [7:0] master_select, // Master positioner index
  output logic [31:0] setpoint, // Corrector setpoint
  output logic setpoint_strobe, // New corrector setpoint
  output logic gearing_active, // Gearing on
  output logic tracking_active // Tracking on
);

  // ----------------------------------------
  // Arithmetic helpers
  // ----------------------------------------
  function automatic logic signed [31:0] agt_mulq(input logic signed [31:0] a,
                                                  input logic signed [31:0] b);
    logic signed [63:0] p;
    p = a * b;
    return p[47:16];
  endfunction

  function automatic logic signed [31:0] agt_clamp(input logic signed [31:0] v,
                                                   input logic signed [31:0] lim);
    logic signed [31:0] r;
    r = v;
    if (v > lim) begin
      r = lim;
    end else if (v < -lim) begin
      r = -lim;
    end
    return r;
  endfunction

  function automatic logic signed [31:0] agt_null_zone(input logic signed [31:0] x,
                                                       input logic signed [31:0] w);
    logic signed [31:0] r;
    r = 32'sh0;
    if (x >= 32'sh0) begin
      r = (x - w < 32'sh0) ? 32'sh0 : x - w;
    end else begin
      r = (x + w > 32'sh0) ? 32'sh0 : x + w;
    end
    return r;
  endfunction

  // ----------------------------------------
  // Registers and bus
  // ----------------------------------------
  logic signed [31:0] ratio, offset, scale, null_width, max_vel, max_acc, corner;
  logic [3:0] order;
  logic [4:0] fs_shift;
  logic cfg_valid, err, track_vel;
  logic signed [31:0] sp_prev, sp_new, last_step, start_pos, filt, pw;
  logic [3:0] pw_cnt;
  logic [2:0] phase;
  logic [15:0] adc_meta, adc_sync;
  logic [31:0] prof_cnt, corr_cnt;
  logic prof_tick, corr_tick;
  agt_pkg::agt_calc_type calc;

  logic acc, wr, rd, mapped;
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign rd = !pwrite;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `AGT_OFF_SETPOINT);

  // One cycle setup, answer in the first access cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable && !pready;
      pslverr <= psel && !penable && !pready && !mapped;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata <= 32'h0;
    end else if (psel && !penable && rd) begin
      case (paddr)
        `AGT_OFF_STAT: prdata <= {27'h0, cfg_valid, err, track_vel, tracking_active,
                                  gearing_active};
        `AGT_OFF_RATIO: prdata <= ratio;
        `AGT_OFF_SLAVE_CFG: prdata <= {24'h0, master_select};
        `AGT_OFF_OFFSET: prdata <= offset;
        `AGT_OFF_SCALE: prdata <= scale;
        `AGT_OFF_NULL: prdata <= null_width;
        `AGT_OFF_ORDER: prdata <= {28'h0, order};
        `AGT_OFF_FULL_SCALE: prdata <= {27'h0, fs_shift};
        `AGT_OFF_MAX_VEL: prdata <= max_vel;
        `AGT_OFF_MAX_ACC: prdata <= max_acc;
        `AGT_OFF_CORNER: prdata <= corner;
        `AGT_OFF_SETPOINT: prdata <= setpoint;
        default: prdata <= 32'h0;
      endcase
    end
  end

  logic cfg_wr, size_ok;
  assign cfg_wr = wr && (paddr == `AGT_OFF_SLAVE_CFG);
  assign size_ok = pwdata[`AGT_CFG_SIZE_LO+3:`AGT_CFG_SIZE_LO] == `AGT_ONE_POSITIONER;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ratio <= `AGT_RST_RATIO;
      offset <= 32'sh0;
      scale <= `AGT_RST_SCALE;
      null_width <= 32'sh0;
      order <= `AGT_RST_ORDER;
      fs_shift <= `AGT_RST_FS_SHIFT;
      max_vel <= `AGT_RST_MAX_VEL;
      max_acc <= `AGT_RST_MAX_ACC;
      corner <= `AGT_RST_CORNER;
      master_select <= 8'h0;
      cfg_valid <= 1'b0;
    end else if (wr) begin
      case (paddr)
        `AGT_OFF_RATIO: ratio <= pwdata;
        `AGT_OFF_SLAVE_CFG: begin
          if (size_ok) begin
            master_select <= pwdata[7:0];
            cfg_valid <= 1'b1;
          end
        end
        `AGT_OFF_OFFSET: offset <= pwdata;
        `AGT_OFF_SCALE: scale <= pwdata;
        `AGT_OFF_NULL: null_width <= pwdata;
        `AGT_OFF_ORDER: order <= pwdata[3:0];
        `AGT_OFF_FULL_SCALE: fs_shift <= pwdata[4:0];
        `AGT_OFF_MAX_VEL: max_vel <= pwdata;
        `AGT_OFF_MAX_ACC: max_acc <= pwdata;
        `AGT_OFF_CORNER: corner <= pwdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Mode commands
  // ----------------------------------------
  logic cmd_wr, gear_on, gear_off, track_on, track_off, gear_ok, track_ok, reject;
  assign cmd_wr = wr && (paddr == `AGT_OFF_CMD);
  assign gear_on = cmd_wr && pwdata[`AGT_CMD_GEAR_ON];
  assign gear_off = cmd_wr && pwdata[`AGT_CMD_GEAR_OFF];
  assign track_on = cmd_wr && pwdata[`AGT_CMD_TRACK_ON];
  assign track_off = cmd_wr && pwdata[`AGT_CMD_TRACK_OFF];
  assign gear_ok = !tracking_active && cfg_valid && slave_state == agt_pkg::grp_ready &&
                   (master_state == agt_pkg::grp_not_referenced ||
                    master_state == agt_pkg::grp_ready);
  assign track_ok = !gearing_active && slave_state == agt_pkg::grp_ready;
  assign reject = (gear_on && !gear_ok) || (track_on && !track_ok) || (cfg_wr && !size_ok);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      gearing_active <= 1'b0;
      tracking_active <= 1'b0;
      track_vel <= 1'b0;
    end else begin
      if (gear_off) begin
        gearing_active <= 1'b0;
      end else if (gear_on && gear_ok) begin
        gearing_active <= 1'b1;
      end
      if (track_off) begin
        tracking_active <= 1'b0;
      end else if (track_on && track_ok) begin
        tracking_active <= 1'b1;
        track_vel <= pwdata[`AGT_CMD_TRACK_VEL];
      end
    end
  end

  // Set wins over a same-cycle write-one-to-clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      err <= 1'b0;
    end else if (reject) begin
      err <= 1'b1;
    end else if (wr && paddr == `AGT_OFF_STAT && pwdata[`AGT_ST_ERR]) begin
      err <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      slave_move_refuse <= 1'b0;
    end else begin
      slave_move_refuse <= gearing_active && slave_move_req;
    end
  end

  // ----------------------------------------
  // Profile and corrector ticks
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prof_cnt <= 32'h0;
      prof_tick <= 1'b0;
      corr_cnt <= 32'h0;
      corr_tick <= 1'b0;
    end else begin
      prof_tick <= prof_cnt == PROFILE_CYC - 1;
      prof_cnt <= (prof_cnt == PROFILE_CYC - 1) ? 32'h0 : prof_cnt + 32'h1;
      // Corrector phase locked to the profile tick
      corr_tick <= corr_cnt == CORR_CYC - 1;
      corr_cnt <= (corr_cnt == CORR_CYC - 1 || prof_cnt == PROFILE_CYC - 1) ? 32'h0 :
                  corr_cnt + 32'h1;
    end
  end

  // ----------------------------------------
  // Analog input filter
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      adc_meta <= 16'h0;
      adc_sync <= 16'h0;
    end else begin
      adc_meta <= adc_sample;
      adc_sync <= adc_meta;
    end
  end

  logic signed [31:0] sample;
  assign sample = {{16{adc_sync[15]}}, adc_sync};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      filt <= 32'sh0;
    end else if (prof_tick) begin
      filt <= filt + agt_mulq(sample - filt, corner);
    end
  end

  // ----------------------------------------
  // Setpoint computation
  // ----------------------------------------
  logic signed [31:0] vel_in, pos_target, gear_target, desired, step_v, step_a;
  logic signed [63:0] pw_prod;
  assign vel_in = agt_null_zone(filt - offset, null_width);
  assign pos_target = start_pos + agt_mulq(filt - offset, scale);
  assign gear_target = agt_mulq(master_fb.pos + master_fb.comp, ratio) - slave_fb.comp;
  assign desired = track_vel ? agt_mulq(vel_in[31] ? -pw : pw, scale) :
                   pos_target - sp_new;
  assign step_v = agt_clamp(desired, max_vel);
  assign step_a = last_step + agt_clamp(step_v - last_step, max_acc);
  assign pw_prod = (pw * (vel_in[31] ? -vel_in : vel_in)) >>> fs_shift;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      calc <= agt_pkg::calc_idle;
      pw <= 32'sh0;
      pw_cnt <= 4'h0;
    end else begin
      case (calc)
        agt_pkg::calc_idle: begin
          if (prof_tick && (gearing_active || tracking_active)) begin
            pw <= 32'sh1 <<< fs_shift;
            pw_cnt <= order;
            calc <= (tracking_active && track_vel) ? agt_pkg::calc_power :
                    agt_pkg::calc_apply;
          end
        end
        agt_pkg::calc_power: begin
          if (pw_cnt == 4'h0) begin
            calc <= agt_pkg::calc_apply;
          end else begin
            pw <= pw_prod[31:0];
            pw_cnt <= pw_cnt - 4'h1;
          end
        end
        agt_pkg::calc_apply: calc <= agt_pkg::calc_idle;
        default: calc <= agt_pkg::calc_idle;
      endcase
    end
  end

  // Disabling freezes the last point; no ramp down is made here
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sp_prev <= 32'sh0;
      sp_new <= 32'sh0;
      last_step <= 32'sh0;
      start_pos <= 32'sh0;
    end else if (track_on && track_ok && !tracking_active) begin
      start_pos <= slave_fb.pos;
      sp_prev <= slave_fb.pos;
      sp_new <= slave_fb.pos;
      last_step <= 32'sh0;
    end else if (gear_on && gear_ok && !gearing_active) begin
      sp_prev <= slave_fb.pos;
      sp_new <= slave_fb.pos;
    end else if (calc == agt_pkg::calc_apply) begin
      sp_prev <= sp_new;
      if (gearing_active) begin
        sp_new <= gear_target;
      end else if (tracking_active) begin
        sp_new <= sp_new + step_a;
        last_step <= step_a;
      end
    end
  end

  logic signed [31:0] sp_diff;
  logic signed [34:0] interp;
  assign sp_diff = sp_new - sp_prev;
  assign interp = (35'(sp_diff) * 35'(phase + 3'h1)) >>> `AGT_INTERP_SHIFT;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase <= 3'h0;
      setpoint <= 32'h0;
      setpoint_strobe <= 1'b0;
    end else begin
      setpoint_strobe <= 1'b0;
      if (calc == agt_pkg::calc_apply) begin
        phase <= 3'h0;
      end else if (corr_tick && (gearing_active || tracking_active)) begin
        setpoint <= sp_prev + interp[31:0];
        setpoint_strobe <= 1'b1;
        if (phase != `AGT_INTERP_LAST) begin
          phase <= phase + 3'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_slave_size_check: assert property (cfg_wr && !size_ok |=> err && $stable(master_select))
    else $error("slave config with wrong group size accepted");
  a_gear_enable_pre: assert property ($rose(gearing_active) |-> $past(gear_ok))
    else $error("gearing enabled without ready groups");
  a_track_enable_pre: assert property ($rose(tracking_active) |->
    $past(slave_state) == agt_pkg::grp_ready)
    else $error("tracking enabled while group not ready");
  a_reject_keeps_state: assert property (gear_on && !gear_ok && !gearing_active
    |=> !gearing_active && err)
    else $error("refused enable changed mode or lacked error");
  a_move_refused: assert property (gearing_active && slave_move_req |=> slave_move_refuse)
    else $error("slave move not refused while geared");
  a_velocity_limit: assert property (calc == agt_pkg::calc_apply && tracking_active &&
    max_acc <= max_vel && max_acc >= 0 && last_step <= max_vel && last_step >= -max_vel
    |=> last_step <= $past(max_vel) && last_step >= -$past(max_vel))
    else $error("tracking step exceeds velocity limit");
  a_null_zone_zero: assert property (filt - offset <= null_width &&
    offset - filt <= null_width |-> vel_in == 32'sh0)
    else $error("motion inside null zone");
  a_track_off_freeze: assert property (!gearing_active && !tracking_active
    |=> $stable(setpoint))
    else $error("setpoint moved with modes off");
  a_profile_period: assert property (prof_tick |=> !prof_tick [*3])
    else $error("profile ticks too close");
  a_gear_follow: assert property (calc == agt_pkg::calc_apply && gearing_active
    |=> sp_new == $past(gear_target))
    else $error("slave does not follow geared master");

  c_gear_on: cover property ($rose(gearing_active));
  c_track_vel: cover property (tracking_active && track_vel && calc == agt_pkg::calc_apply);
  c_rejected: cover property (reject);

endmodule

`default_nettype wire

// ===== agt_partner.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Groups and positioners on the far side
// ----------------------------------------
module agt_partner (
  input wire logic clk, // 100 MHz clock
  input wire logic nrst, // Synchronous reset
  input wire agt_pkg::agt_group_type want_master, // Host-chosen master state
  input wire agt_pkg::agt_group_type want_slave, // Host-chosen slave state
  input wire logic signed [31:0] m_pos, // Master base position
  input wire logic signed [31:0] m_comp, // Master compensation
  input wire logic signed [31:0] m_step, // Master motion per cycle while moving
  input wire logic signed [31:0] s_pos, // Slave position
  input wire logic signed [31:0] s_comp, // Slave compensation
  output var agt_pkg::agt_axis_type master_fb, // Master feedback
  output var agt_pkg::agt_axis_type slave_fb, // Slave feedback
  output var agt_pkg::agt_group_type master_state, // Master group state
  output var agt_pkg::agt_group_type slave_state // Slave group state
);
  logic signed [31:0] moved;

  // States change only when the host has driven them there first
  always_ff @(posedge clk) begin
    if (!nrst) begin
      master_state <= agt_pkg::grp_not_referenced;
      slave_state <= agt_pkg::grp_not_referenced;
    end else begin
      master_state <= want_master;
      slave_state <= want_slave;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      moved <= 32'h0;
    end else if (master_state == agt_pkg::grp_moving) begin
      moved <= moved + m_step;
    end
  end

  assign master_fb = '{pos: m_pos + moved, comp: m_comp};
  assign slave_fb = '{pos: s_pos, comp: s_comp};
endmodule

`default_nettype wire

// ===== axis_gearing_analog_tracking_test.sv
`timescale 1ns/1ps
`default_nettype none

module axis_gearing_analog_tracking_test;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, setpoint, rd, prev, sp0;
  logic pready, pslverr, er, refuse, strobe, gear_on, track_on;
  logic [15:0] adc = 16'h0;
  logic move_req = 1'b0;
  logic [7:0] msel, mi;
  logic signed [31:0] m_pos = 32'h0, m_comp = 32'h0, s_pos = 32'h0, s_comp = 32'h0;
  agt_pkg::agt_group_type want_m = agt_pkg::grp_not_referenced;
  agt_pkg::agt_group_type want_s = agt_pkg::grp_not_referenced;
  agt_pkg::agt_group_type mst, sst;
  agt_pkg::agt_axis_type mfb, sfb;
  int fails = 0, samples_checked = 0, d, c;
  longint ex;
  logic [7:0] ra[$] = '{8'h04, 8'h08, 8'h0c, 8'h14, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c};
  logic [31:0] rv[$] = '{0, 32'h10000, 0, 32'h10000, 1, 32'hf, 32'h1000, 32'h100, 32'h1000};

  always #5 clk = ~clk;

  agt_partner u_partner (.clk(clk), .nrst(nrst), .want_master(want_m), .want_slave(want_s),
    .m_pos(m_pos), .m_comp(m_comp), .m_step(32'sh1), .s_pos(s_pos), .s_comp(s_comp),
    .master_fb(mfb), .slave_fb(sfb), .master_state(mst), .slave_state(sst));

  agt_core #(.PROFILE_CYC(40), .CORR_CYC(10)) DUT (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .adc_sample(adc), .master_fb(mfb), .slave_fb(sfb),
    .slave_state(sst), .master_state(mst), .slave_move_req(move_req),
    .slave_move_refuse(refuse), .master_select(msel), .setpoint(setpoint),
    .setpoint_strobe(strobe), .gearing_active(gear_on), .tracking_active(track_on));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // Request stands until pready is seen high at a rising edge
    do begin
      @(posedge clk);
      n++;
    end while (!(pready === 1'b1 && psel === 1'b1 && penable === 1'b1) && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50) fails++;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let registered mode outputs settle before callers look at them
    @(negedge clk);
  endtask

  // Bounded wait for one corrector strobe; returns cycles waited
  task automatic ws(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (strobe !== 1'b1 && n < 100);
    if (n >= 100) fails++;
  endtask

  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #(1_000_000);
    fails++;
    end_sim();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'hcdf30fff));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    foreach (ra[i]) begin
      apb(0, ra[i], 0);
      chk("reset value", rv[i], rd);
    end
    apb(0, 8'h34, 0);
    chk("unmapped err", 1, er);
    chk("unmapped data", 0, rd);
    apb(1, 8'h02, 32'hffff);
    chk("unaligned err", 1, er);
    $display("test registers done");
    mi = $urandom;
    apb(1, 8'h0c, {20'h0, 4'h2, mi});
    apb(0, 8'h04, 0);
    chk("cfg two positioners", 32'h8, rd);
    apb(1, 8'h04, 32'h8);
    apb(1, 8'h0c, {20'h0, 4'h1, mi});
    apb(0, 8'h04, 0);
    chk("cfg one positioner", 32'h10, rd);
    chk("master select", mi, msel);
    $display("test configuration done");
    m_pos <= $urandom_range(0, 16'hffff);
    m_comp <= $urandom_range(0, 255);
    s_comp <= 32'sh5;
    want_m <= agt_pkg::grp_ready;
    apb(1, 8'h08, 32'h20000);
    apb(1, 8'h00, 32'h1);
    apb(0, 8'h04, 0);
    chk("gear slave not ready", 32'h18, rd);
    apb(1, 8'h04, 32'h8);
    want_s <= agt_pkg::grp_ready;
    want_m <= agt_pkg::grp_moving;
    apb(1, 8'h00, 32'h1);
    chk("gear master moving", 0, gear_on);
    apb(1, 8'h04, 32'h8);
    want_m <= agt_pkg::grp_not_referenced;
    apb(1, 8'h00, 32'h1);
    apb(0, 8'h04, 0);
    chk("gear enabled", 32'h11, rd);
    @(posedge clk);
    move_req <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk("slave move refused", 1, refuse);
    move_req <= 1'b0;
    repeat (16) ws(d);
    ws(d);
    // Master feedback includes any travel made while it was moving
    ex = ((longint'(mfb.pos) + longint'(mfb.comp)) * 32'h20000 >>> 16) - longint'(sfb.comp);
    chk("gear setpoint", ex[31:0], setpoint);
    ws(d);
    chk("corrector period", 10, d);
    apb(1, 8'h00, 32'h2);
    chk("gear off", 0, gear_on);
    $display("test gearing done");
    s_comp <= 32'sh0;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk("reset setpoint", 0, setpoint);
    apb(1, 8'h10, 32'h100);
    apb(1, 8'h2c, 32'h10000);
    apb(1, 8'h24, 32'h4);
    apb(1, 8'h28, 32'h1000);
    adc <= 16'h114;
    want_s <= agt_pkg::grp_homing;
    apb(1, 8'h00, 32'h4);
    chk("track while homing", 0, track_on);
    apb(1, 8'h04, 32'h8);
    want_s <= agt_pkg::grp_ready;
    apb(1, 8'h00, 32'h4);
    chk("track on", 1, track_on);
    prev = setpoint;
    repeat (40) begin
      ws(c);
      d = $signed(setpoint) - $signed(prev);
      chk("step bound", 1, (d <= 4 && d >= -4));
      prev = setpoint;
    end
    chk("position target", 32'd20, setpoint);
    apb(1, 8'h00, 32'h8);
    c = 0;
    repeat (100) begin
      @(negedge clk);
      c += strobe;
    end
    chk("no strobe when off", 0, c);
    chk("frozen setpoint", 32'd20, setpoint);
    $display("test position tracking done");
    apb(1, 8'h18, 32'h1000);
    apb(1, 8'h10, 32'h0);
    apb(1, 8'h00, 32'h14);
    apb(0, 8'h04, 0);
    chk("velocity mode", 32'h6, rd);
    ws(d);
    sp0 = setpoint;
    repeat (20) begin
      adc <= 16'($urandom_range(0, 16'h1ffe)) - 16'h0fff;
      ws(d);
      chk("null zone", sp0, setpoint);
    end
    apb(1, 8'h00, 32'h8);
    for (int s = 0; s < 2; s++) begin
      adc <= (s == 0) ? 16'h3000 + 16'($urandom_range(0, 255)) : 16'hd000;
      apb(1, 8'h1c, s + 1);
      apb(1, 8'h00, 32'h14);
      sp0 = setpoint;
      repeat (20) ws(d);
      d = $signed(setpoint) - $signed(sp0);
      chk("velocity sign", 1, (s == 0) ? d > 0 : d < 0);
      apb(1, 8'h00, 32'h8);
    end
    $display("test velocity tracking done");
    end_sim();
  end
endmodule

`default_nettype wire
